// File: port_cd_pkg.sv
// package: register map, field positions and reset values for port c/d pin control
package port_cd_pkg;
    localparam int          ADDR_W          = 4;
    // register byte offsets on the wishbone bus
    localparam logic [3:0]  OFS_PC_FUNC     = 4'h0;
    localparam logic [3:0]  OFS_PD_DIR      = 4'h4;
    localparam logic [3:0]  OFS_PD_FUNC_HI  = 4'h8;
    localparam logic [3:0]  OFS_PD_FUNC_LO  = 4'hc;
    localparam logic [3:0]  OFS_PIN_DATA    = 4'h0;
    // writable bit masks; all other bits read zero
    localparam logic [15:0] PC_FUNC_MASK    = 16'h0155;
    localparam logic [15:0] PD_DIR_MASK     = 16'h3fff;
    localparam logic [15:0] PD_FUNC_HI_MASK = 16'h0d55;
    localparam logic [15:0] PD_FUNC_LO_MASK = 16'h5555;
    // values after reset
    localparam logic [15:0] PC_FUNC_RST     = 16'h0000;
    localparam logic [15:0] PD_DIR_RST      = 16'h0000;
    localparam logic [15:0] PD_FUNC_HI_RST  = 16'h0000;
    localparam logic [15:0] PD_FUNC_LO_RST  = 16'h0000;
    // pin 13 selection field
    localparam int          PD13_SEL_LSB    = 10;
    localparam logic [1:0]  PD13_GPIO       = 2'h0;
    localparam logic [1:0]  PD13_PULSE      = 2'h1;
    localparam logic [1:0]  PD13_CAN        = 2'h2;
    localparam int          PC_PINS         = 5;
    localparam int          PD_PINS         = 14;
endpackage : port_cd_pkg

// File: pin_sync.sv
// file: two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : pin_sync
`default_nettype wire

// File: port_cd_pin_function_control.sv
// file: port c/d pin function and direction control with wishbone register slave
//
// Function
// - power-on/standby reset clears, watchdog reset doesn't
// - registers hold through software standby and sleep
// - port c function reserved bits read zero
// - pc bit 8: pin4 gpio or interrupt input
// - pc bit 6: pin3 gpio or serial2 receive
// - pc bit 4: pin2 gpio or serial2 transmit
// - pc bit 2: pin1 gpio or serial1 receive
// - pc bit 0: pin0 gpio or serial1 transmit
// - pd direction bits 13:0, 15:14 read zero
// - direction applies only for gpio or timer
// - port d function split high/low registers
// - pd high function reserved bits read zero
// - pd high 11:10 selects pin13 function
// - pd high bit 8: pin12 pulse output 4
// - pd high bit 6: pin11 pulse output 3
// - pd high bit 4: pin10 pulse output 2
// - pd high bit 2: pin9 pulse output 1
// - pd high bit 0: pin8 pulse output 0
// - pd low even bits select timer channel
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module port_cd_pin_function_control
    import port_cd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        watchdog_reset,
    input  wire logic        hw_standby,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // general i/o data from the port data registers
    input  wire logic [4:0]  pc_gpio_out,
    input  wire logic [4:0]  pc_gpio_dir,
    input  wire logic [13:0] pd_gpio_out,
    // peripheral sources
    input  wire logic        serial1_transmit_out,
    input  wire logic        serial2_transmit_out,
    input  wire logic [4:0]  pulse_out,
    input  wire logic        pulse_out6,
    input  wire logic        can_transmit_out,
    input  wire logic [7:0]  timer_compare_out,
    // package pins
    input  wire logic [4:0]  pc_pin_i,
    output logic      [4:0]  pc_pin_o,
    output logic      [4:0]  pc_pin_oe,
    input  wire logic [13:0] pd_pin_i,
    output logic      [13:0] pd_pin_o,
    output logic      [13:0] pd_pin_oe,
    // synchronised pin levels toward peripherals
    output logic             external_interrupt_in0,
    output logic             serial2_receive_in,
    output logic             serial1_receive_in,
    output logic      [7:0]  timer_capture_compare_io,
    output logic      [4:0]  pc_gpio_in,
    output logic      [13:0] pd_gpio_in
);
    logic [15:0] pc_func_q, pc_func_d;
    logic [15:0] pd_dir_q, pd_dir_d;
    logic [15:0] pd_hi_q, pd_hi_d;
    logic [15:0] pd_lo_q, pd_lo_d;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [4:0]  pc_sync;
    logic [13:0] pd_sync;
    logic        cfg_clear_q;

    // bus decode
    wire         req      = wb_cyc_i & wb_stb_i & ~ack_q;
    wire         wr       = req & wb_we_i;
    wire         hit_pc   = wb_adr_i == OFS_PC_FUNC;
    wire         hit_dir  = wb_adr_i == OFS_PD_DIR;
    wire         hit_hi   = wb_adr_i == OFS_PD_FUNC_HI;
    wire         hit_lo   = wb_adr_i == OFS_PD_FUNC_LO;
    wire [15:0]  be_mask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [15:0]  wdat     = wb_dat_i[15:0];

    // merge write data under byte enables and writable mask
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [15:0] be, input logic [15:0] m);
        merge = ((old & ~be) | (nw & be)) & m;
    endfunction : merge

    // reserved bits never store, so they always read zero
    assign pc_func_d = (wr && hit_pc) ? merge(pc_func_q, wdat, be_mask, PC_FUNC_MASK)
                                      : pc_func_q;
    assign pd_dir_d  = (wr && hit_dir) ? merge(pd_dir_q, wdat, be_mask, PD_DIR_MASK)
                                       : pd_dir_q;
    assign pd_hi_d   = (wr && hit_hi) ? merge(pd_hi_q, wdat, be_mask, PD_FUNC_HI_MASK)
                                      : pd_hi_q;
    assign pd_lo_d   = (wr && hit_lo) ? merge(pd_lo_q, wdat, be_mask, PD_FUNC_LO_MASK)
                                      : pd_lo_q;

    // read mux; unmapped offsets answer with zero
    wire [15:0] rsel = hit_pc  ? pc_func_q :
                       hit_dir ? pd_dir_q  :
                       hit_hi  ? pd_hi_q   :
                       hit_lo  ? pd_lo_q   : 16'h0000;

    // standby clears synchronously; watchdog_reset is not connected, so it never reaches the flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_clear_q <= 1'b0;
        end else begin
            cfg_clear_q <= hw_standby;
        end
    end

    // config registers: sleep/software standby have no path here, contents hold
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_func_q <= PC_FUNC_RST;
            pd_dir_q  <= PD_DIR_RST;
            pd_hi_q   <= PD_FUNC_HI_RST;
            pd_lo_q   <= PD_FUNC_LO_RST;
        end else if (cfg_clear_q) begin
            pc_func_q <= PC_FUNC_RST;
            pd_dir_q  <= PD_DIR_RST;
            pd_hi_q   <= PD_FUNC_HI_RST;
            pd_lo_q   <= PD_FUNC_LO_RST;
        end else begin
            pc_func_q <= pc_func_d;
            pd_dir_q  <= pd_dir_d;
            pd_hi_q   <= pd_hi_d;
            pd_lo_q   <= pd_lo_d;
        end
    end

    // one registered ack per request, one cycle after it, dropped the next cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= req;
            rdat_q <= req ? {16'h0000, rsel} : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // pins come from outside the clock domain
    pin_sync #(.W(PC_PINS)) u_pc_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (pc_pin_i),
        .sync_out (pc_sync)
    );
    pin_sync #(.W(PD_PINS)) u_pd_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (pd_pin_i),
        .sync_out (pd_sync)
    );

    // port c mode bits
    wire pc4_m = pc_func_q[8];
    wire pc3_m = pc_func_q[6];
    wire pc2_m = pc_func_q[4];
    wire pc1_m = pc_func_q[2];
    wire pc0_m = pc_func_q[0];

    // port c output/enable: inputs in peripheral mode never drive
    wire [4:0] pc_o_d  = {pc4_m ? 1'b0 : pc_gpio_out[4],
                          pc3_m ? 1'b0 : pc_gpio_out[3],
                          pc2_m ? serial2_transmit_out : pc_gpio_out[2],
                          pc1_m ? 1'b0 : pc_gpio_out[1],
                          pc0_m ? serial1_transmit_out : pc_gpio_out[0]};
    wire [4:0] pc_oe_d = {pc4_m ? 1'b0 : pc_gpio_dir[4],
                          pc3_m ? 1'b0 : pc_gpio_dir[3],
                          pc2_m ? 1'b1 : pc_gpio_dir[2],
                          pc1_m ? 1'b0 : pc_gpio_dir[1],
                          pc0_m ? 1'b1 : pc_gpio_dir[0]};

    // pin13: reserved code 11 decodes as general i/o
    wire [1:0] pd13_sel = pd_hi_q[PD13_SEL_LSB +: 2];
    wire       pd13_pls = pd13_sel == PD13_PULSE;
    wire       pd13_can = pd13_sel == PD13_CAN;
    wire       pd13_per = pd13_pls | pd13_can;
    wire       pd13_src = pd13_pls ? pulse_out6 : can_transmit_out;

    // upper pins 12..8 single-bit pulse selects
    wire [4:0] pd_up_m  = {pd_hi_q[8], pd_hi_q[6], pd_hi_q[4], pd_hi_q[2], pd_hi_q[0]};
    // high register drives pins 13..8, low register pins 7..0
    wire [7:0] pd_lo_m;
    logic [13:0] pd_o_d, pd_oe_d;

    // per-pin muxes for port d
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pd_low
            assign pd_lo_m[g]  = pd_lo_q[2*g];
            assign pd_o_d[g]   = pd_lo_m[g] ? timer_compare_out[g] : pd_gpio_out[g];
            assign pd_oe_d[g]  = pd_dir_q[g];               // timer pins keep direction
        end
        for (g = 0; g < 5; g++) begin : g_pd_up
            assign pd_o_d[8+g]  = pd_up_m[g] ? pulse_out[g] : pd_gpio_out[8+g];
            assign pd_oe_d[8+g] = pd_up_m[g] ? 1'b1 : pd_dir_q[8+g];
        end
    endgenerate
    assign pd_o_d[13]  = pd13_per ? pd13_src : pd_gpio_out[13];
    assign pd_oe_d[13] = pd13_per ? 1'b1 : pd_dir_q[13];

    // registered pin drive and output enables, selected by mode
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_pin_o  <= 5'h00;
            pc_pin_oe <= 5'h00;
            pd_pin_o  <= 14'h0000;
            pd_pin_oe <= 14'h0000;
        end else begin
            pc_pin_o  <= pc_o_d;
            pc_pin_oe <= pc_oe_d;
            pd_pin_o  <= pd_o_d;
            pd_pin_oe <= pd_oe_d;
        end
    end

    // idle levels when not selected: serial lines mark high, others low
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            external_interrupt_in0   <= 1'b0;
            serial2_receive_in       <= 1'b1;
            serial1_receive_in       <= 1'b1;
            timer_capture_compare_io <= 8'h00;
            pc_gpio_in               <= 5'h00;
            pd_gpio_in               <= 14'h0000;
        end else begin
            external_interrupt_in0   <= pc4_m ? pc_sync[4] : 1'b0;
            serial2_receive_in       <= pc3_m ? pc_sync[3] : 1'b1;
            serial1_receive_in       <= pc1_m ? pc_sync[1] : 1'b1;
            timer_capture_compare_io <= pd_sync[7:0] & pd_lo_m;
            pc_gpio_in               <= pc_sync;
            pd_gpio_in               <= pd_sync;
        end
    end
endmodule : port_cd_pin_function_control
`default_nettype wire

// File: port_cd_chk.sv
// checker: bus timing and pin routing of the port c/d control block
`timescale 1ns/1ps
`default_nettype none
module port_cd_chk
    import port_cd_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        hw_standby,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [4:0]  pc_gpio_out,
    input wire logic [13:0] pd_gpio_out,
    input wire logic        serial1_transmit_out,
    input wire logic [4:0]  pulse_out,
    input wire logic        pulse_out6,
    input wire logic [4:0]  pc_pin_o,
    input wire logic [4:0]  pc_pin_oe,
    input wire logic [13:0] pd_pin_o
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [15:0] pc_q, ph_q;
    logic        up_q;
    logic [1:0]  sb_q;
    // shadow copies lag the real registers by one edge, as the pins do
    wire [15:0] bm = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [15:0] wd = wb_dat_i[15:0] & bm;
    wire        wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {pc_q, ph_q, up_q, sb_q} <= '0;
        end else begin
            up_q <= 1'b1;
            // two stages: the real clear lands one edge after standby, the pins one more
            sb_q <= {sb_q[0], hw_standby};
            if (sb_q[1]) begin
                {pc_q, ph_q} <= '0;
            end else if (wr && wb_adr_i == OFS_PC_FUNC) begin
                pc_q <= (pc_q & ~bm) | (wd & PC_FUNC_MASK);
            end else if (wr && wb_adr_i == OFS_PD_FUNC_HI) begin
                ph_q <= (ph_q & ~bm) | (wd & PD_FUNC_HI_MASK);
            end
        end
    end
    chk_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a one cycle pulse");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_pc_resv: assert property (wb_ack_o && wb_adr_i == OFS_PC_FUNC
        |-> (wb_dat_o & ~{16'h0, PC_FUNC_MASK}) == 32'h0) else $error("pc reserved bit set");
    chk_pdh_resv: assert property (wb_ack_o && wb_adr_i == OFS_PD_FUNC_HI
        |-> (wb_dat_o & ~{16'h0, PD_FUNC_HI_MASK}) == 32'h0) else $error("pdh reserved set");
    chk_pc0_tx: assert property (pc_q[0] |-> pc_pin_oe[0]
        && pc_pin_o[0] == $past(serial1_transmit_out)) else $error("pin0 not serial1 tx");
    chk_pc4_irq: assert property (pc_q[8] |-> !pc_pin_oe[4])
        else $error("pin4 driven in irq mode");
    chk_pc0_gpio: assert property (up_q && !pc_q[0]
        |-> pc_pin_o[0] == $past(pc_gpio_out[0])) else $error("pin0 not gpio data");
    chk_pd13_pulse: assert property (ph_q[11:10] == PD13_PULSE
        |-> pd_pin_o[13] == $past(pulse_out6)) else $error("pin13 not pulse 6");
    chk_pd13_resv: assert property (up_q && ph_q[11:10] == 2'h3
        |-> pd_pin_o[13] == $past(pd_gpio_out[13])) else $error("pin13 code 3 not gpio");
    chk_pd8_pulse: assert property (ph_q[0] |-> pd_pin_o[8] == $past(pulse_out[0]))
        else $error("pin8 not pulse 0");
    // main scenarios reached
    cov_pdh_write: cover property (wr && wb_adr_i == OFS_PD_FUNC_HI);
    cov_pd13_resv: cover property (ph_q[11:10] == 2'h3);
    cov_standby: cover property (hw_standby ##1 !hw_standby);
endmodule : port_cd_chk
bind port_cd_pin_function_control port_cd_chk i_port_cd_chk (.*);
`default_nettype wire

// File: port_cd_far_side.sv
// partner: package pins and external devices of ports c and d
`timescale 1ns/1ps
`default_nettype none
module port_cd_far_side (
    input  wire logic [4:0]  pc_pin_o,
    input  wire logic [4:0]  pc_pin_oe,
    input  wire logic [13:0] pd_pin_o,
    input  wire logic [13:0] pd_pin_oe,
    input  wire logic        clk,
    input  wire logic [18:0] ext_en,
    input  wire logic [18:0] ext_val,
    output logic      [4:0]  pc_pin_i,
    output logic      [13:0] pd_pin_i
);
    logic [18:0] tog_q = 19'h0;
    logic [18:0] oe;
    // a floating pin toggles so a stale level never passes for a match
    always @(posedge clk) tog_q <= ~tog_q;
    // pin level: block drive, else external device, else float
    assign oe = {pd_pin_oe, pc_pin_oe};
    assign {pd_pin_i, pc_pin_i} = (oe & {pd_pin_o, pc_pin_o})
        | (~oe & ext_en & ext_val) | (~oe & ~ext_en & tog_q);
endmodule : port_cd_far_side
`default_nettype wire

// File: testbench.sv
// testbench: registers, pin routing and resets of the port c/d control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench
    import port_cd_pkg::*;
;
    logic        clk, sys_rst, watchdog_reset, hw_standby, can_transmit_out;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pulse_out6;
    logic        serial1_transmit_out, serial2_transmit_out, external_interrupt_in0;
    logic        serial2_receive_in, serial1_receive_in;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [4:0]  pc_gpio_out, pc_gpio_dir, pulse_out, pc_pin_i, pc_pin_o, pc_pin_oe, pc_gpio_in;
    logic [7:0]  timer_compare_out, timer_capture_compare_io;
    logic [13:0] pd_gpio_out, pd_pin_i, pd_pin_o, pd_pin_oe, pd_gpio_in;
    logic [18:0] ext_en, ext_val;
    logic [15:0] rd_q;
    int          mismatches, cmp_count, cycles;
    logic [3:0]  ofs [4] = '{OFS_PC_FUNC, OFS_PD_DIR, OFS_PD_FUNC_HI, OFS_PD_FUNC_LO};
    logic [15:0] msk [4] = '{PC_FUNC_MASK, PD_DIR_MASK, PD_FUNC_HI_MASK, PD_FUNC_LO_MASK};
    port_cd_pin_function_control i_port_cd_pin_function_control (.*);
    port_cd_far_side i_port_cd_far_side (.*);
    // 40 mhz clock and a hang guard far beyond the roughly one hundred cycles needed
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            summarize();
        end
    end
    task summarize;
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    // classic single cycle: hold everything until ack is sampled
    task wb(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_dat_i <= {16'h0, d};
        wb_sel_i <= 4'h3;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rd_q = wb_dat_o[15:0];
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    task rd(input logic [3:0] a, input logic [15:0] e);
        wb(1'b0, a, 16'h0);
        `CHK("register", e, rd_q)
    endtask : rd
    // main sequence
    initial begin
        {sys_rst, watchdog_reset, hw_standby, wb_cyc_i, wb_stb_i, wb_we_i} = 6'h20;
        {wb_adr_i, wb_sel_i, wb_dat_i, pc_gpio_out, pc_gpio_dir, pd_gpio_out} = '0;
        {serial1_transmit_out, serial2_transmit_out, pulse_out, pulse_out6} = '0;
        {can_transmit_out, timer_compare_out, ext_en, ext_val} = '0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], 16'h0);
        foreach (ofs[i]) begin
            wb(1'b1, ofs[i], 16'hffff);
            rd(ofs[i], msk[i]);
        end
        wb(1'b1, OFS_PD_DIR, 16'h0001);
        {serial1_transmit_out, pulse_out, pd_gpio_out[13]} <= {1'b1, 5'h15, 1'b1};
        timer_compare_out <= 8'ha5;
        ext_en <= 19'h0001a;
        ext_val <= 19'h00010;
        repeat (5) @(posedge clk);
        `CHK("pc_oe", 5'h05, pc_pin_oe)
        `CHK("pc_tx", 2'b01, {pc_pin_o[2], pc_pin_o[0]})
        `CHK("rx", 3'h4, {external_interrupt_in0, serial2_receive_in, serial1_receive_in})
        `CHK("pd_hi", 6'h35, pd_pin_o[13:8])
        `CHK("pd_lo", 8'ha5, pd_pin_o[7:0])
        `CHK("pd_oe", 14'h1f01, pd_pin_oe)
        `CHK("pd0_in", 2'b11, {timer_capture_compare_io[0], pd_gpio_in[0]})
        // each pin 13 code; for codes 0 to 2 the chosen source alone is low, for code 3 all sources are high
        for (int c = 0; c < 4; c++) begin
            {pd_gpio_out[13], pulse_out6, can_transmit_out} <= {c != 0, c != 1, c != 2};
            wb(1'b1, OFS_PD_FUNC_HI, {4'h0, c[1:0], 10'h155});
            repeat (3) @(posedge clk);
            `CHK("pd13", c == 3, pd_pin_o[13])
            `CHK("pd13_oe", c == 1 || c == 2, pd_pin_oe[13])
        end
        watchdog_reset <= 1'b1;
        repeat (3) @(posedge clk);
        watchdog_reset <= 1'b0;
        rd(OFS_PC_FUNC, 16'h0155);
        hw_standby <= 1'b1;
        repeat (3) @(posedge clk);
        hw_standby <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], 16'h0);
        {pc_gpio_out, pc_gpio_dir} <= {5'h0a, 5'h0f};
        repeat (5) @(posedge clk);
        `CHK("pc_gpio", 15'h29fa, {pc_pin_o, pc_pin_oe, pc_gpio_in})
        summarize();
    end
endmodule : testbench
`default_nettype wire
